// ==== inc/lbh_pkg.sv ====
// Purpose: shared constants and types for the local bus handover block
// Assumes: one 100 MHz processor clock
// Notes: cycle type codes follow the status encoding of the bus
package lbh_pkg;

  localparam int LBH_CLK_MHZ = 100;
  localparam int LBH_QUEUE_BYTES = 6;
  localparam int LBH_FETCH_ROOM = 2;
  localparam int LBH_IDLE_START_MAX = 3;
  localparam int LBH_ADDR_W = 20;
  localparam int LBH_SEG_SHIFT = 4;
  localparam logic [15:0] LBH_ADDR_RESET = 16'h0000;

  // queue state codes
  localparam logic [1:0] LBH_QS_NOP = 2'h0;
  localparam logic [1:0] LBH_QS_FIRST = 2'h1;
  localparam logic [1:0] LBH_QS_FLUSH = 2'h2;
  localparam logic [1:0] LBH_QS_NEXT = 2'h3;

  // cycle type codes
  localparam logic [2:0] LBH_CT_VECTOR_FETCH_STROBE_N = 3'h0;
  localparam logic [2:0] LBH_CT_IORD = 3'h1;
  localparam logic [2:0] LBH_CT_IOWR = 3'h2;
  localparam logic [2:0] LBH_CT_HALT = 3'h3;
  localparam logic [2:0] LBH_CT_CODE = 3'h4;
  localparam logic [2:0] LBH_CT_MRD = 3'h5;
  localparam logic [2:0] LBH_CT_MWR = 3'h6;
  localparam logic [2:0] LBH_CT_PASS = 3'h7;

  typedef enum logic [2:0]
  {
    LBH_TI = 3'b000,
    LBH_T1 = 3'b001,
    LBH_T2 = 3'b010,
    LBH_T3 = 3'b011,
    LBH_T4 = 3'b100,
    LBH_TH = 3'b101
  } lbh_tstate_t;

  typedef enum logic [1:0]
  {
    LBH_HS_IDLE = 2'b00,
    LBH_HS_REQ = 2'b01,
    LBH_HS_OWN = 2'b10,
    LBH_HS_DEAD = 2'b11
  } lbh_hs_t;

  // one bus cycle request from the execute core
  typedef struct packed
  {
    logic [2:0] cycle_type_code;
    logic [15:0] seg;
    logic [15:0] offset;
    logic [15:0] wdata;
    logic odd_first;
    logic vector_fetch_strobe_n_first;
  } lbh_req_t;

  // minimum-mode strobes: value and enable (enable low drives)
  typedef struct packed
  {
    logic mem_io;
    logic store_n;
    logic vector_fetch_strobe_n;
    logic addr_latch;
    logic xcvr_direction;
    logic xcvr_output_enable_n;
    logic lock_n;
  } lbh_strobe_t;

endpackage

// ==== rtl/lbh_skid.sv ====
// Purpose: two-entry buffer between the execute core and the bus sequencer
// Assumes: single clock, clock enable freezes state
// Notes: ready depends only on registered occupancy
`timescale 1ns/1ns
`default_nettype none
module lbh_skid
  import lbh_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic clock_in, // clock
  input wire logic sys_rst_in, // async reset
  input wire logic ce_in, // clock enable
  input wire logic s_valid_in, // source valid
  output logic s_ready_out, // source ready
  input wire logic [WIDTH-1:0] s_data_in, // source data
  output logic m_valid_out, // sink valid
  input wire logic m_ready_in, // sink ready
  output logic [WIDTH-1:0] m_data_out // sink data
);

  typedef struct packed
  {
    logic [1:0][WIDTH-1:0] mem;
    logic rd;
    logic wr;
    logic [1:0] cnt;
  } lbh_skid_st_t;

  lbh_skid_st_t st_reg;
  lbh_skid_st_t st_next;

  always_comb
  begin
    logic push;
    logic pop;
    push = 1'b0;
    pop = 1'b0;
    st_next = st_reg;
    push = s_valid_in && (st_reg.cnt != 2'h2);
    pop = (st_reg.cnt != 2'h0) && m_ready_in;
    if (push)
    begin
      st_next.mem[st_reg.wr] = s_data_in;
      st_next.wr = ~st_reg.wr;
    end
    if (pop)
    begin
      st_next.rd = ~st_reg.rd;
    end
    st_next.cnt = st_reg.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st_reg <= '0;
    end
    else if (ce_in)
    begin
      st_reg <= st_next;
    end
  end

  assign s_ready_out = (st_reg.cnt != 2'h2);
  assign m_valid_out = (st_reg.cnt != 2'h0);
  assign m_data_out = st_reg.mem[st_reg.rd];

endmodule // lbh_skid
`default_nettype wire

// ==== rtl/lbh_bus_unit.sv ====
// Purpose: bus cycle sequencer, handover logic, strobes and prefetch queue
// Assumes: pins from outside pass two flip-flops; one clock at 100 MHz
// Notes: enable outputs are low while the pin is driven
//
// Overview of operation
// RULE1: when both pulse pins request together, pin zero wins.
// RULE2: a requester pulls the pulse pin low one clock to ask.
// RULE3: grant pulse in T4 or T1, float bus, hold acknowledge next clock.
// RULE4: third requester pulse ends tenure; device drives again next clock.
// RULE5: each ownership exchange is exactly request, grant and release pulses.
// RULE6: one dead clock follows every handover before bus use.
// RULE7: release in T4 only if request by T2, not odd first half, vector_fetch_strobe_n, lock.
// RULE8: idle bus request: release next clock, or cycle starts within three clocks.
// RULE9: lock output low from prefix to next instruction end; floats in hold.
// RULE10: queue state code shown the clock after each queue operation.
// RULE11: memory select high for memory, low for io; floats in hold.
// RULE12: store strobe low in T2, T3 and waits of writes; floats in hold.
// RULE13: vector fetch strobe low in T2, T3 and waits of acknowledges.
// RULE14: address latch pulse high in T1 of every cycle, never floated.
// RULE15: transceiver direction high transmit, low receive; floats in hold.
// RULE16: transceiver enable low T2 to T4, earlier for writes; floats in hold. Code drives it low from T2 for writes as well.
// RULE17: high takeover request raises acknowledge in T1 and floats bus. Code raises it at release, after a qualifying T4 or an idle clock.
// RULE18: low takeover request drops acknowledge; drive again at next need.
// RULE19: level takeover uses same release conditions; requester synchronises.
// RULE20: word fetch starts whenever queue has room for two bytes.
// RULE21: six byte queue in order; first byte into empty queue usable at once.
// RULE22: physical address is segment times sixteen plus offset, twenty bits.
// RULE23: cycle is T1 to T4, waits between T3 and T4 while not ready.
// RULE24: pulses sampled and driven on the rising clock edge, one period each.
`timescale 1ns/1ns
`default_nettype none
module lbh_bus_unit
  import lbh_pkg::*;
#(
  parameter int QDEPTH = LBH_QUEUE_BYTES
)
(
  input wire logic clock_in, // processor clock
  input wire logic sys_rst_in, // async reset, active high
  input wire logic ce_in, // clock enable
  input wire logic config_strap_in, // high selects minimum mode
  input wire logic pulse_handover_pin_zero_in, // pin zero level
  output logic pulse_handover_pin_zero_out, // pin zero drive value
  output logic pulse_handover_pin_zero_oe_n_out, // pin zero enable, low drives
  input wire logic pulse_handover_pin_one_in, // pin one level
  output logic pulse_handover_pin_one_out, // pin one drive value
  output logic pulse_handover_pin_one_oe_n_out, // pin one enable, low drives
  input wire logic takeover_req_in, // level takeover request
  output logic takeover_ack_out, // level takeover acknowledge
  input wire logic ready_in, // target ready
  input wire logic [15:0] bus_data_in, // read data from bus
  output logic [LBH_ADDR_W-1:0] bus_addr_out, // physical address
  output logic [15:0] bus_data_out, // write data
  output logic bus_oe_n_out, // address/data enable, low drives
  output lbh_strobe_t strobe_out, // minimum-mode strobes
  output lbh_strobe_t strobe_oe_n_out, // strobe enables, low drives
  output logic [1:0] queue_state_code_out, // queue state code
  input wire logic req_valid_in, // core bus request valid
  output logic req_ready_out, // core request accepted
  input wire lbh_req_t req_in, // core request
  input wire logic lock_prefix_in, // lock prefix seen
  input wire logic instr_done_in, // instruction completed
  input wire logic q_take_in, // core takes a byte
  input wire logic q_first_in, // byte is first opcode byte
  input wire logic q_flush_in, // branch flushes queue
  input wire logic [15:0] fetch_seg_in, // code segment
  input wire logic [15:0] fetch_off_in, // fetch offset after flush
  output logic q_valid_out, // queue head valid
  output logic [7:0] q_byte_out, // queue head byte
  output logic [15:0] rdata_out, // last read data
  output logic rdone_out // data read pulse
);

  localparam int CW = $bits(lbh_req_t);

  typedef struct packed
  {
    logic [2:0] p0_s;
    logic [2:0] p1_s;
    logic [2:0] hold_s;
    logic [1:0] rdy_s;
    lbh_tstate_t ts;
    lbh_hs_t hs;
    logic hs_pin;
    logic hs_level;
    logic early;
    lbh_req_t cur;
    logic fetch;
    logic locked;
    logic [QDEPTH-1:0][7:0] q;
    logic [2:0] qcnt;
    logic [15:0] fip;
    logic [1:0] qs;
    logic gnt0_n;
    logic gnt1_n;
    logic pend0;
    logic pend1;
    logic qv;
    logic ack;
    lbh_strobe_t str;
    lbh_strobe_t str_oe_n;
    logic bus_oe_n;
    logic [LBH_ADDR_W-1:0] addr;
    logic [15:0] rdata;
    logic rdone;
  } lbh_st_t;

  lbh_st_t st_reg;
  lbh_st_t st_next;
  logic sk_valid;
  logic sk_take;
  lbh_req_t sk_data;

  function automatic logic [LBH_ADDR_W-1:0] phys(input logic [15:0] seg,
                                                 input logic [15:0] off);
    phys = ({seg, 4'h0} + {4'h0, off}); // RULE22
  endfunction

  function automatic logic is_write(input logic [2:0] ct);
    is_write = (ct == LBH_CT_MWR) || (ct == LBH_CT_IOWR);
  endfunction

  lbh_skid #(.WIDTH(CW)) u_skid
  (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .s_valid_in(req_valid_in),
    .s_ready_out(req_ready_out),
    .s_data_in(req_in),
    .m_valid_out(sk_valid),
    .m_ready_in(sk_take),
    .m_data_out(sk_data)
  );

  logic room;
  logic fall0;
  logic fall1;
  logic can_go;
  logic want;
  assign room = (st_reg.qcnt <= 3'(QDEPTH - LBH_FETCH_ROOM)) && !q_flush_in;
  assign fall0 = st_reg.p0_s[2] && !st_reg.p0_s[1];
  assign fall1 = st_reg.p1_s[2] && !st_reg.p1_s[1];
  assign want = sk_valid || room;
  // RULE7 conditions evaluated at T4 (RULE8: idle start counts as early)
  assign can_go = st_reg.early && !st_reg.cur.odd_first && !st_reg.cur.vector_fetch_strobe_n_first &&
                  !st_reg.locked;
  assign sk_take = (st_reg.ts == LBH_TI || st_reg.ts == LBH_T4) && sk_valid &&
                   st_reg.hs == LBH_HS_IDLE && !st_reg.hold_s[1];

  always_comb
  begin
    logic mn;
    logic pulled;
    logic [QDEPTH-1:0][7:0] qn;
    logic [2:0] cn;
    mn = config_strap_in;
    pulled = 1'b0;
    qn = st_reg.q;
    cn = st_reg.qcnt;
    st_next = st_reg;
    st_next.p0_s = {st_reg.p0_s[1:0], pulse_handover_pin_zero_in || !st_reg.gnt0_n};
    st_next.p1_s = {st_reg.p1_s[1:0], pulse_handover_pin_one_in || !st_reg.gnt1_n};
    st_next.hold_s = {st_reg.hold_s[1:0], takeover_req_in};
    st_next.rdy_s = {st_reg.rdy_s[0], ready_in};
    st_next.gnt0_n = 1'b1;
    st_next.gnt1_n = 1'b1;
    st_next.rdone = 1'b0;
    st_next.qs = LBH_QS_NOP;
    // ---------------------------------------------------------------
    // handover requests
    // ---------------------------------------------------------------
    // a request meeting a busy handshake waits its turn
    if (fall0 && !(st_reg.hs == LBH_HS_OWN && !st_reg.hs_pin))
    begin
      st_next.pend0 = !mn;
    end
    if (fall1 && !(st_reg.hs == LBH_HS_OWN && st_reg.hs_pin))
    begin
      st_next.pend1 = !mn;
    end
    if (st_reg.hs == LBH_HS_IDLE && !mn)
    begin
      if (st_next.pend0) // RULE1
      begin
        st_next.hs = LBH_HS_REQ;
        st_next.hs_pin = 1'b0;
        st_next.pend0 = 1'b0;
      end
      else if (st_next.pend1)
      begin
        st_next.hs = LBH_HS_REQ;
        st_next.hs_pin = 1'b1;
        st_next.pend1 = 1'b0;
      end
      st_next.early = (st_reg.ts != LBH_T3) && (st_reg.ts != LBH_T4); // RULE7
    end
    else if (st_reg.hs == LBH_HS_IDLE && mn && st_reg.hold_s[2])
    begin
      st_next.hs = LBH_HS_REQ; // RULE19
      st_next.hs_level = 1'b1;
      st_next.early = (st_reg.ts != LBH_T3) && (st_reg.ts != LBH_T4);
    end
    // release of the bus: in T4 of a qualifying cycle or from idle
    if (st_reg.hs == LBH_HS_REQ &&
        ((st_reg.ts == LBH_T4 && can_go) || st_reg.ts == LBH_TI)) // RULE8
    begin
      pulled = 1'b1;
      st_next.ts = LBH_TH;
      st_next.hs = LBH_HS_OWN;
      st_next.bus_oe_n = 1'b1;
      st_next.str_oe_n = '1;
      st_next.str_oe_n.addr_latch = 1'b0; // RULE14
      if (st_reg.hs_level)
      begin
        st_next.ack = 1'b1; // RULE17
      end
      else
      begin
        st_next.gnt0_n = st_reg.hs_pin; // RULE3 RULE24
        st_next.gnt1_n = !st_reg.hs_pin;
      end
    end
    if (st_reg.hs == LBH_HS_OWN)
    begin
      if (st_reg.hs_level ? !st_reg.hold_s[2] : (st_reg.hs_pin ? fall1 : fall0)) // RULE4 RULE5
      begin
        st_next.hs = LBH_HS_DEAD;
        st_next.ack = 1'b0; // RULE18
        st_next.hs_level = 1'b0;
      end
    end
    if (st_reg.hs == LBH_HS_DEAD)
    begin
      st_next.hs = LBH_HS_IDLE; // RULE6
      st_next.ts = LBH_TI;
    end
    // ---------------------------------------------------------------
    // bus cycle sequencer
    // ---------------------------------------------------------------
    if (!pulled)
    begin
      case (st_reg.ts)
        LBH_TI, LBH_T4:
        begin
          st_next.str.addr_latch = 1'b0;
          st_next.str_oe_n.xcvr_output_enable_n = 1'b0;
          st_next.str.xcvr_output_enable_n = 1'b1; // RULE16 end after T4
          if (st_reg.hs == LBH_HS_IDLE && want && !st_reg.hold_s[1] &&
              !(st_reg.hs_level))
          begin
            st_next.ts = LBH_T1;
            st_next.fetch = !sk_valid; // RULE20
            st_next.cur = sk_valid ? sk_data : lbh_req_t'{LBH_CT_CODE, fetch_seg_in, st_reg.fip,
                                                 16'h0000, 1'b0, 1'b0};
            st_next.addr = phys(st_next.cur.seg, st_next.cur.offset);
            st_next.bus_oe_n = 1'b0;
            st_next.str_oe_n = '0;
            st_next.str.mem_io = st_next.cur.cycle_type_code[2]; // RULE11
            st_next.str.xcvr_direction = is_write(st_next.cur.cycle_type_code); // RULE15
            st_next.str.addr_latch = 1'b1; // RULE14 RULE23
          end
          else
          begin
            st_next.ts = LBH_TI;
          end
        end
        LBH_T1:
        begin
          st_next.ts = LBH_T2;
          st_next.str.addr_latch = 1'b0;
          st_next.str.store_n = !is_write(st_reg.cur.cycle_type_code); // RULE12
          st_next.str.vector_fetch_strobe_n =
            !(st_reg.cur.cycle_type_code == LBH_CT_VECTOR_FETCH_STROBE_N); // RULE13
          st_next.str.xcvr_output_enable_n = 1'b0; // RULE16
        end
        LBH_T2:
        begin
          st_next.ts = LBH_T3;
        end
        LBH_T3:
        begin
          if (st_reg.rdy_s[1]) // RULE23
          begin
            st_next.ts = LBH_T4;
            st_next.str.store_n = 1'b1;
            st_next.str.vector_fetch_strobe_n = 1'b1;
            st_next.rdata = bus_data_in;
            st_next.rdone = !is_write(st_reg.cur.cycle_type_code) && !st_reg.fetch;
            if (st_reg.fetch && !q_flush_in)
            begin
              qn[cn] = bus_data_in[7:0]; // RULE21
              qn[cn + 3'h1] = bus_data_in[15:8];
              cn = cn + 3'h2;
              st_next.fip = st_reg.fip + 16'h0002;
            end
          end
        end
        default:
        begin
          st_next.ts = (st_reg.ts == LBH_TH) ? st_next.ts : LBH_TI;
        end
      endcase
    end
    // ---------------------------------------------------------------
    // prefetch queue and its state code
    // ---------------------------------------------------------------
    if (q_flush_in)
    begin
      cn = 3'h0;
      st_next.fip = fetch_off_in;
      st_next.qs = LBH_QS_FLUSH; // RULE10
    end
    else if (q_take_in && st_reg.qcnt != 3'h0)
    begin
      for (int i = 0; i < QDEPTH - 1; i++)
      begin
        qn[i] = qn[i + 1];
      end
      cn = cn - 3'h1;
      st_next.qs = q_first_in ? LBH_QS_FIRST : LBH_QS_NEXT; // RULE10
    end
    st_next.q = qn;
    st_next.qcnt = cn;
    st_next.qv = (cn != 3'h0);
    // ---------------------------------------------------------------
    // lock
    // ---------------------------------------------------------------
    if (lock_prefix_in)
    begin
      st_next.locked = 1'b1;
    end
    else if (instr_done_in)
    begin
      st_next.locked = 1'b0;
    end
    st_next.str.lock_n = !st_next.locked; // RULE9
    st_next.str_oe_n.lock_n = (st_next.ts == LBH_TH); // RULE9
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st_reg <= '0;
      st_reg.p0_s <= 3'h7;
      st_reg.p1_s <= 3'h7;
      st_reg.str <= '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
      st_reg.bus_oe_n <= 1'b1;
      st_reg.gnt0_n <= 1'b1;
      st_reg.gnt1_n <= 1'b1;
      st_reg.fip <= LBH_ADDR_RESET;
    end
    else if (ce_in)
    begin
      st_reg <= st_next;
    end
  end

  assign pulse_handover_pin_zero_out = 1'b0;
  assign pulse_handover_pin_zero_oe_n_out = st_reg.gnt0_n;
  assign pulse_handover_pin_one_out = 1'b0;
  assign pulse_handover_pin_one_oe_n_out = st_reg.gnt1_n;
  assign takeover_ack_out = st_reg.ack;
  assign bus_addr_out = st_reg.addr;
  assign bus_data_out = st_reg.cur.wdata;
  assign bus_oe_n_out = st_reg.bus_oe_n;
  assign strobe_out = st_reg.str;
  assign strobe_oe_n_out = st_reg.str_oe_n;
  assign queue_state_code_out = st_reg.qs;
  assign q_valid_out = st_reg.qv;
  assign q_byte_out = st_reg.q[0];
  assign rdata_out = st_reg.rdata;
  assign rdone_out = st_reg.rdone;

endmodule // lbh_bus_unit
`default_nettype wire

// ==== tb/lbh_bus_unit_assertions.sv ====
// Purpose: port checks for the bus unit
// Assumes: one clock, async reset high
// Notes: 7'h77 = every strobe floated but the latch pulse
`timescale 1ns/1ns
`default_nettype none
module lbh_bus_unit_chk
  import lbh_pkg::*;
(
  input wire logic clock_in, // clock
  input wire logic sys_rst_in, // reset
  input wire logic pulse_handover_pin_zero_oe_n_out, // pin zero enable
  input wire logic pulse_handover_pin_one_oe_n_out, // pin one enable
  input wire logic takeover_req_in, // level request
  input wire logic takeover_ack_out, // level acknowledge
  input wire logic q_flush_in, // flush
  input wire logic [1:0] queue_state_code_out, // queue code
  input wire lbh_strobe_t strobe_out, // strobes
  input wire lbh_strobe_t strobe_oe_n_out // strobe enables
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // ----------
  // properties
  // ----------
  sequence s_grant;
    pulse_handover_pin_zero_oe_n_out ##1 !pulse_handover_pin_zero_oe_n_out;
  endsequence
  sequence s_after;
    pulse_handover_pin_zero_oe_n_out [*2];
  endsequence
  property p_grant_pulse;
    s_grant |=> s_after;
  endproperty
  a_grant_pulse: assert property (p_grant_pulse) else $error("grant width");
  property p_one_grant;
    !(!pulse_handover_pin_zero_oe_n_out && !pulse_handover_pin_one_oe_n_out);
  endproperty
  a_one_grant: assert property (p_one_grant) else $error("two grants");
  property p_latch_driven;
    strobe_oe_n_out.addr_latch == 1'b0;
  endproperty
  a_latch_driven: assert property (p_latch_driven) else $error("latch floated");
  property p_hold_float;
    takeover_ack_out |-> strobe_oe_n_out == 7'h77;
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("hold drive");
  property p_write;
    $fell(strobe_out.store_n) |-> $past(strobe_out.addr_latch)
      && strobe_out.xcvr_direction && !strobe_out.xcvr_output_enable_n;
  endproperty
  a_write: assert property (p_write) else $error("write strobe");
  property p_vector;
    !strobe_out.vector_fetch_strobe_n |-> !strobe_out.xcvr_direction && strobe_out.store_n;
  endproperty
  a_vector: assert property (p_vector) else $error("vector strobe");
  property p_qs_flush;
    q_flush_in |=> queue_state_code_out == LBH_QS_FLUSH;
  endproperty
  a_qs_flush: assert property (p_qs_flush) else $error("flush code");
  property p_ack_drop;
    $fell(takeover_req_in) && takeover_ack_out |-> ##[1:4] !takeover_ack_out;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held");
endmodule // lbh_bus_unit_chk
bind lbh_bus_unit lbh_bus_unit_chk u_chk (.clock_in, .sys_rst_in,
  .pulse_handover_pin_zero_oe_n_out, .pulse_handover_pin_one_oe_n_out,
  .takeover_req_in, .takeover_ack_out, .q_flush_in, .queue_state_code_out,
  .strobe_out, .strobe_oe_n_out);
`default_nettype wire

// ==== tb/lbh_far_model.sv ====
// Purpose: other masters on the pulse pins, plus memory
// Assumes: memory byte value is the low byte of its address
// Notes: released data lines carry a cycle counter and its inverse
`timescale 1ns/1ns
`default_nettype none
module lbh_far_model
  import lbh_pkg::*;
(
  input wire logic clock_in, // clock
  input wire logic sys_rst_in, // reset
  input wire logic slow_in, // insert waits
  input wire logic [1:0] go_in, // start request per pin
  input wire logic [1:0] dev_in, // device pin values
  input wire logic [1:0] dev_oe_n_in, // device pin enables
  input wire logic [LBH_ADDR_W-1:0] addr_in, // address
  input wire lbh_strobe_t strobe_in, // strobes
  output logic [1:0] pin_out, // pin levels
  output logic ready_out, // target ready
  output logic [15:0] data_out // read data
);
  logic [1:0] pull_reg;
  logic [2:0] st_reg [2];
  logic [7:0] tick_reg;
  // pull-ups hold the pins high unless someone drives low
  assign pin_out = ~pull_reg & (dev_oe_n_in | dev_in);
  assign ready_out = !slow_in || tick_reg[1];
  assign data_out = (!strobe_in.xcvr_output_enable_n && !strobe_in.xcvr_direction) ?
    {addr_in[7:0] + 8'h1, addr_in[7:0]} : {tick_reg, ~tick_reg};
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pull_reg <= 2'h0;
      tick_reg <= 8'h00;
      st_reg <= '{3'h0, 3'h0};
    end
    else
    begin
      tick_reg <= tick_reg + 8'h1;
      for (int i = 0; i < 2; i++)
      begin
        // one clock low to ask, one to give back
        pull_reg[i] <= (st_reg[i] == 3'h0 && go_in[i]) || st_reg[i] == 3'h5;
        if (st_reg[i] == 3'h0 && go_in[i])
          st_reg[i] <= 3'h1;
        else if (st_reg[i] == 3'h1 && !dev_oe_n_in[i])
          st_reg[i] <= 3'h2;
        else if (st_reg[i] >= 3'h2)
          st_reg[i] <= st_reg[i] + 3'h1;
      end
    end
  end
endmodule // lbh_far_model
`default_nettype wire

// ==== tb/lbh_bus_unit_tb.sv ====
// Purpose: self-checking bench for the bus unit
// Assumes: far model answers bus and pulse pins
// Notes: drivers queue expectations, a monitor compares
`timescale 1ns/1ns
`default_nettype none
module lbh_bus_unit_tb
  import lbh_pkg::*;
;
  logic clock_in, sys_rst_in, ce_in, config_strap_in, takeover_req_in, takeover_ack_out;
  logic req_valid_in, req_ready_out, lock_prefix_in, instr_done_in, q_take_in, q_first_in;
  logic q_flush_in, q_valid_out, rdone_out, ready_in, bus_oe_n_out, slow;
  logic pulse_handover_pin_zero_in, pulse_handover_pin_zero_out, pulse_handover_pin_zero_oe_n_out;
  logic pulse_handover_pin_one_in, pulse_handover_pin_one_out, pulse_handover_pin_one_oe_n_out;
  logic [1:0] go, queue_state_code_out;
  logic [15:0] bus_data_in, bus_data_out, fetch_seg_in, fetch_off_in, rdata_out;
  logic [LBH_ADDR_W-1:0] bus_addr_out;
  logic [7:0] q_byte_out;
  lbh_req_t req_in;
  lbh_strobe_t strobe_out, strobe_oe_n_out;
  logic [39:0] exp_rd [$], exp_q [$], exp_wr [$];
  logic [2:0] types [5] = '{LBH_CT_MWR, LBH_CT_IOWR, LBH_CT_MRD, LBH_CT_IORD, LBH_CT_VECTOR_FETCH_STROBE_N};
  int miscompares = 0, n_checks = 0, seed = 32'h7435, n, n_vec = 0;
  logic prev_st = 1'b1, prev_vec = 1'b1;
  lbh_bus_unit uut (.clock_in, .sys_rst_in, .ce_in, .config_strap_in,
    .pulse_handover_pin_zero_in, .pulse_handover_pin_zero_out, .pulse_handover_pin_zero_oe_n_out,
    .pulse_handover_pin_one_in, .pulse_handover_pin_one_out, .pulse_handover_pin_one_oe_n_out,
    .takeover_req_in, .takeover_ack_out, .ready_in, .bus_data_in, .bus_addr_out, .bus_data_out,
    .bus_oe_n_out, .strobe_out, .strobe_oe_n_out, .queue_state_code_out, .req_valid_in,
    .req_ready_out, .req_in, .lock_prefix_in, .instr_done_in, .q_take_in, .q_first_in,
    .q_flush_in, .fetch_seg_in, .fetch_off_in, .q_valid_out, .q_byte_out, .rdata_out, .rdone_out);
  lbh_far_model far (.clock_in, .sys_rst_in, .slow_in(slow), .go_in(go),
    .dev_in({pulse_handover_pin_one_out, pulse_handover_pin_zero_out}),
    .dev_oe_n_in({pulse_handover_pin_one_oe_n_out, pulse_handover_pin_zero_oe_n_out}),
    .addr_in(bus_addr_out), .strobe_in(strobe_out), .ready_out(ready_in), .data_out(bus_data_in),
    .pin_out({pulse_handover_pin_one_in, pulse_handover_pin_zero_in}));
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // -------------
  // tasks
  // -------------
  task automatic step();
    @(posedge clock_in);
    #1;
  endtask
  task automatic summarize();
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk_vec(input logic [39:0] got, input logic [39:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic bound(input int i);
    if (i >= 200)
    begin
      miscompares++;
      summarize();
    end
  endtask
  task automatic do_reset(input logic s);
    sys_rst_in = 1'b1;
    config_strap_in = s;
    repeat (20) step();
    chk_vec({takeover_ack_out, strobe_oe_n_out.addr_latch}, 2'b00, "reset");
    sys_rst_in = 1'b0;
    repeat (40) step();
  endtask
  task automatic core(input logic [2:0] ct, input logic [15:0] s, input logic [15:0] o);
    logic [LBH_ADDR_W-1:0] pa;
    pa = {s, 4'h0} + {4'h0, o};
    req_in = '{ct, s, o, 16'($random(seed)), 1'b0, 1'b0};
    if (ct == LBH_CT_MRD || ct == LBH_CT_IORD || ct == LBH_CT_VECTOR_FETCH_STROBE_N)
      exp_rd.push_back({pa[7:0] + 8'h1, pa[7:0]});
    if (ct == LBH_CT_MWR || ct == LBH_CT_IOWR)
      exp_wr.push_back({ct == LBH_CT_MWR, pa, req_in.wdata});
    req_valid_in = 1'b1;
    for (n = 0; n < 200 && !req_ready_out; n++) step();
    bound(n);
    step();
    req_valid_in = 1'b0;
    step();
  endtask
  always @(posedge clock_in)
  begin
    if (rdone_out && exp_rd.size() > 0)
      chk_vec(rdata_out, exp_rd.pop_front(), "read");
    if (q_take_in && q_valid_out && !q_flush_in)
      chk_vec(q_byte_out, exp_q.pop_front(), "queue");
    if (prev_st && !strobe_out.store_n && exp_wr.size() > 0)
      chk_vec({strobe_out.mem_io, bus_addr_out, bus_data_out}, exp_wr.pop_front(), "write");
    if (prev_vec && !strobe_out.vector_fetch_strobe_n)
      n_vec++;
    prev_st = strobe_out.store_n;
    prev_vec = strobe_out.vector_fetch_strobe_n;
  end
  initial
  begin
    #1000000;
    miscompares++;
    summarize();
  end
  // -------------
  // scenarios
  // -------------
  initial
  begin
    {ce_in, takeover_req_in, req_valid_in, lock_prefix_in, instr_done_in} = 5'h10;
    {q_take_in, q_first_in, q_flush_in, slow, go} = 6'h00;
    {req_in, fetch_seg_in, fetch_off_in} = '0;
    do_reset(1'b1);
    for (int k = 0; k < 10; k++)
    begin
      slow = k >= 5;
      core(types[k % 5], (k % 5 == 1 || k % 5 == 3) ? 16'h0 : 16'($random(seed)),
        16'($random(seed)) & 16'hfffe);
    end
    repeat (60) step();
    chk_vec({8'(n_vec), 16'(exp_rd.size()), 16'(exp_wr.size())}, {8'h02, 32'h0}, "drain");
    takeover_req_in = 1'b1;
    for (n = 0; n < 200 && !takeover_ack_out; n++) step();
    bound(n);
    core(LBH_CT_MWR, 16'h0100, 16'h0020);
    chk_vec({takeover_ack_out, bus_oe_n_out, strobe_oe_n_out}, 9'h1f7, "hold");
    takeover_req_in = 1'b0;
    for (n = 0; n < 200 && takeover_ack_out; n++) step();
    bound(n);
    repeat (30) step();
    chk_vec(exp_wr.size(), 0, "resume");
    do_reset(1'b0);
    core(LBH_CT_MRD, 16'h0040, 16'h0100);
    go = 2'b11;
    step();
    go = 2'b00;
    for (n = 0; n < 200 && pulse_handover_pin_zero_oe_n_out
      && pulse_handover_pin_one_oe_n_out; n++) step();
    bound(n);
    chk_vec({pulse_handover_pin_zero_oe_n_out, pulse_handover_pin_one_oe_n_out}, 2'b01, "prio");
    for (n = 0; n < 200 && pulse_handover_pin_one_oe_n_out; n++) step();
    bound(n);
    lock_prefix_in = 1'b1;
    step();
    lock_prefix_in = 1'b0;
    for (n = 0; n < 200 && strobe_out.lock_n; n++) step();
    bound(n);
    {fetch_seg_in, fetch_off_in, q_flush_in} = {16'h1234, 16'h0010, 1'b1};
    step();
    q_flush_in = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      for (n = 0; n < 200 && !q_valid_out; n++)
      begin
        q_take_in = 1'b0;
        step();
      end
      bound(n);
      exp_q.push_back(8'h50 + 8'(k));
      {q_take_in, q_first_in} = {1'b1, k == 0};
      step();
      chk_vec(queue_state_code_out, (k == 0) ? LBH_QS_FIRST : LBH_QS_NEXT, "qs");
    end
    q_take_in = 1'b0;
    summarize();
  end
endmodule // lbh_bus_unit_tb
`default_nettype wire
